// ### hdl/shcp_top.v
`include "shcp_regs.vh"

// ==========================================================
// Slave-only serial host command port with SPI and I2C links.
module shcp_top (
	input wire clk_in,
	input wire srst_in,
	input wire serial_port_select_pin_in,
	input wire bus_addr_strap_high_in,
	input wire bus_addr_strap_low_in,
	input wire temp_trigger_source_in,
	input wire general_port_zero_in,
	input wire spi_sclk_in,
	input wire spi_mosi_in,
	output wire general_port_one_out,
	output wire general_port_one_oe_out,
	output wire general_ports_spi_owned_out,
	input wire i2c_scl_in,
	input wire i2c_sda_in,
	output wire i2c_sda_out,
	output wire i2c_sda_oe_out,
	output wire por_reset_out,
	output wire partial_reset_out,
	output wire cap_start_out,
	output wire temp_start_out,
	output wire otp_term_out,
	output wire mem_wr_out,
	output wire mem_rd_out,
	output wire mem_otp_out,
	output wire [`SHCP_ADDR_W-1:0] mem_addr_out,
	output wire [7:0] mem_wdata_out,
	input wire [7:0] mem_rdata_in,
	output wire cfg_wr_out,
	output wire [`SHCP_IDX_W-1:0] cfg_index_out,
	output wire [23:0] cfg_data_out,
	output wire res_rd_out,
	output wire [`SHCP_IDX_W-1:0] res_index_out,
	input wire [47:0] res_data_in,
	input wire res_wide_in
);
	wire [7:0] pin_s;
	wire sel_s;
	wire ssn_s;
	wire sclk_s;
	wire mosi_s;
	wire scl_s;
	wire sda_s;
	wire strap_h_s;
	wire strap_l_s;

	// Every used pin input passes two flip-flops first; link select low, slave select high, clocks and data at their idle levels in reset.
	shcp_sync #(.W(8), .RST_VAL(8'h4C)) u_sync (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.async_in({serial_port_select_pin_in, general_port_zero_in, spi_sclk_in, spi_mosi_in,
			i2c_scl_in, i2c_sda_in, bus_addr_strap_high_in, bus_addr_strap_low_in}),
		.sync_out(pin_s)
	);
	assign sel_s = pin_s[7];
	assign ssn_s = pin_s[6];
	assign sclk_s = pin_s[5];
	assign mosi_s = pin_s[4];
	assign scl_s = pin_s[3];
	assign sda_s = pin_s[2];
	assign strap_h_s = pin_s[1];
	assign strap_l_s = pin_s[0];

	// ==========================================================
	// Edge detection on synchronised pins
	reg sel_d_ff;
	reg ssn_d_ff;
	reg sclk_d_ff;
	reg scl_d_ff;
	reg sda_d_ff;

	always @(posedge clk_in) begin
		if (srst_in) begin
			sel_d_ff <= 1'b0;
			ssn_d_ff <= 1'b1;
			sclk_d_ff <= 1'b0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			sel_d_ff <= sel_s;
			ssn_d_ff <= ssn_s;
			sclk_d_ff <= sclk_s;
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	wire spi_en = ~sel_s;
	wire i2c_en = sel_s;
	wire sel_chg = sel_s ^ sel_d_ff;
	wire spi_fall = spi_en & ~ssn_s & sclk_d_ff & ~sclk_s;
	wire spi_rise = spi_en & ~ssn_s & ~sclk_d_ff & sclk_s;
	wire spi_end = spi_en & ~ssn_d_ff & ssn_s;
	wire i2c_start = i2c_en & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire i2c_stop = i2c_en & scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	wire scl_rise = i2c_en & ~scl_d_ff & scl_s;
	wire scl_fall = i2c_en & scl_d_ff & ~scl_s;

	// SPI claims general ports zero and one.
	assign general_ports_spi_owned_out = spi_en;

	// ==========================================================
	// Command state shared by both links
	reg [2:0] byte_idx_ff;
	reg [7:0] op_ff;
	reg [7:0] b1_ff;
	reg [7:0] b2_ff;
	reg [7:0] rd_data_ff;
	reg [47:0] res_data_ff;
	reg res_wide_ff;
	reg rd_wait_ff;
	reg res_wait_ff;

	// class decode from the opcode byte.
	wire cls_sram_rd = (op_ff[7:4] == `SHCP_SRAM_RD_NIB);
	wire cls_otp_rd = (op_ff[7:5] == `SHCP_OTP_RD_PFX);
	wire cls_res_rd = (op_ff[7:6] == `SHCP_RES_RD_PFX);

	// Byte to transmit at the current position of a read.
	reg [7:0] cur_tx;
	always @* begin
		cur_tx = 8'h00;
		if ((cls_sram_rd | cls_otp_rd) && byte_idx_ff == 3'h2) begin
			cur_tx = rd_data_ff;
		end else if (cls_res_rd && res_wide_ff) begin
			case (byte_idx_ff)
				3'h1: cur_tx = res_data_ff[47:40];
				3'h2: cur_tx = res_data_ff[39:32];
				3'h3: cur_tx = res_data_ff[31:24];
				3'h4: cur_tx = res_data_ff[23:16];
				3'h5: cur_tx = res_data_ff[15:8];
				3'h6: cur_tx = res_data_ff[7:0];
				default: cur_tx = 8'h00;
			endcase
		end else if (cls_res_rd) begin
			case (byte_idx_ff)
				3'h1: cur_tx = res_data_ff[23:16];
				3'h2: cur_tx = res_data_ff[15:8];
				3'h3: cur_tx = res_data_ff[7:0];
				default: cur_tx = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// SPI link
	reg [2:0] spi_cnt_ff;
	reg [7:0] spi_sr_ff;
	reg miso_ff;
	reg miso_oe_ff;
	wire [7:0] spi_byte = {spi_sr_ff[6:0], mosi_s};
	wire spi_stb = spi_fall & (spi_cnt_ff == 3'h7);

	// sample on falling edge, shift out on rising, MSB first.
	always @(posedge clk_in) begin
		if (srst_in || sel_chg || spi_end) begin
			spi_cnt_ff <= 3'h0;
			spi_sr_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else begin
			if (spi_fall) begin
				spi_sr_ff <= spi_byte;
				spi_cnt_ff <= spi_cnt_ff + 3'h1;
			end
			if (spi_rise) begin
				miso_ff <= cur_tx[3'h7 - spi_cnt_ff];
			end
		end
	end

	// MISO is driven only while this slave is selected.
	always @(posedge clk_in) begin
		if (srst_in) begin
			miso_oe_ff <= 1'b0;
		end else begin
			miso_oe_ff <= spi_en & ~ssn_s;
		end
	end
	assign general_port_one_out = miso_ff;
	// The enable drops in the same cycle that the link select leaves SPI.
	assign general_port_one_oe_out = miso_oe_ff & spi_en;

	// ==========================================================
	// I2C link
	reg [1:0] i2c_st_ff;
	reg [3:0] i2c_cnt_ff;
	reg [7:0] i2c_sr_ff;
	reg sda_oe_ff;
	reg nxt_ack_hit;
	wire i2c_ack_fall = scl_fall & (i2c_cnt_ff == 4'h8);
	wire addr_match = (i2c_sr_ff[7:3] == `SHCP_I2C_PREFIX) && (i2c_sr_ff[2:1] == {strap_h_s, strap_l_s});
	wire i2c_stb = i2c_ack_fall & (i2c_st_ff == `SHCP_I2C_WR);
	wire i2c_tx_done = i2c_ack_fall & (i2c_st_ff == `SHCP_I2C_RD);

	always @* begin
		nxt_ack_hit = 1'b0;
		if (i2c_st_ff == `SHCP_I2C_ADDR) begin
			nxt_ack_hit = addr_match;
		end else if (i2c_st_ff == `SHCP_I2C_WR) begin
			nxt_ack_hit = 1'b1;
		end
	end

	// I2C bit engine; data moves on SCL low, sampled on SCL rise.
	always @(posedge clk_in) begin
		if (srst_in || sel_chg || i2c_stop) begin
			i2c_st_ff <= `SHCP_I2C_IDLE;
			i2c_cnt_ff <= 4'h0;
			i2c_sr_ff <= 8'h00;
			sda_oe_ff <= 1'b0;
		end else if (i2c_start) begin
			i2c_st_ff <= `SHCP_I2C_ADDR;
			i2c_cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (scl_rise && i2c_st_ff != `SHCP_I2C_IDLE) begin
			i2c_cnt_ff <= i2c_cnt_ff + 4'h1;
			if (i2c_cnt_ff < 4'h8) begin
				i2c_sr_ff <= {i2c_sr_ff[6:0], sda_s};
			end else if (i2c_cnt_ff == 4'h8 && i2c_st_ff == `SHCP_I2C_RD && sda_s) begin
				i2c_st_ff <= `SHCP_I2C_IDLE;
			end
		end else if (scl_fall && i2c_st_ff != `SHCP_I2C_IDLE) begin
			if (i2c_cnt_ff == 4'h8) begin
				// low acknowledge after address and written bytes.
				// slave drives only acknowledge bits in writes.
				sda_oe_ff <= nxt_ack_hit;
				if (i2c_st_ff == `SHCP_I2C_ADDR) begin
					// read bit switches to slave transmit.
					i2c_st_ff <= ~addr_match ? `SHCP_I2C_IDLE :
						(i2c_sr_ff[0] ? `SHCP_I2C_RD : `SHCP_I2C_WR);
				end
			end else if (i2c_cnt_ff == 4'h9) begin
				i2c_cnt_ff <= 4'h0;
				sda_oe_ff <= (i2c_st_ff == `SHCP_I2C_RD) & ~cur_tx[7];
			end else if (i2c_st_ff == `SHCP_I2C_RD) begin
				sda_oe_ff <= ~cur_tx[3'h7 - i2c_cnt_ff[2:0]];
			end
		end
	end
	assign i2c_sda_out = 1'b0;
	assign i2c_sda_oe_out = sda_oe_ff;

	// ==========================================================
	// Command decoder and executor
	wire rx_stb = spi_stb | i2c_stb;
	wire [7:0] rx_byte = spi_stb ? spi_byte : i2c_sr_ff;
	wire frame_end = spi_end | i2c_stop | sel_chg;
	reg por_ff;
	reg partial_ff;
	reg cap_ff;
	reg temp_ff;
	reg otp_end_ff;
	reg mem_wr_ff;
	reg mem_rd_ff;
	reg mem_otp_ff;
	reg [`SHCP_ADDR_W-1:0] mem_addr_ff;
	reg [7:0] mem_wdata_ff;
	reg cfg_wr_ff;
	reg [`SHCP_IDX_W-1:0] cfg_idx_ff;
	reg [23:0] cfg_data_ff;
	reg res_rd_ff;
	reg [`SHCP_IDX_W-1:0] res_idx_ff;

	always @(posedge clk_in) begin
		if (srst_in) begin
			byte_idx_ff <= 3'h0;
			op_ff <= 8'h00;
			b1_ff <= 8'h00;
			b2_ff <= 8'h00;
			por_ff <= 1'b0;
			partial_ff <= 1'b0;
			cap_ff <= 1'b0;
			temp_ff <= 1'b0;
			otp_end_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			mem_rd_ff <= 1'b0;
			mem_otp_ff <= 1'b0;
			mem_addr_ff <= {`SHCP_ADDR_W{1'b0}};
			mem_wdata_ff <= 8'h00;
			cfg_wr_ff <= 1'b0;
			cfg_idx_ff <= {`SHCP_IDX_W{1'b0}};
			cfg_data_ff <= 24'h000000;
			res_rd_ff <= 1'b0;
			res_idx_ff <= {`SHCP_IDX_W{1'b0}};
		end else begin
			por_ff <= 1'b0;
			partial_ff <= 1'b0;
			cap_ff <= 1'b0;
			temp_ff <= 1'b0;
			otp_end_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			mem_rd_ff <= 1'b0;
			cfg_wr_ff <= 1'b0;
			res_rd_ff <= 1'b0;
			if (frame_end) begin
				byte_idx_ff <= 3'h0;
			end else if (rx_stb) begin
				if (byte_idx_ff != 3'h7) begin
					byte_idx_ff <= byte_idx_ff + 3'h1;
				end
				case (byte_idx_ff)
					3'h0: begin
						op_ff <= rx_byte;
						por_ff <= (rx_byte == `SHCP_OP_POR);
						partial_ff <= (rx_byte == `SHCP_OP_PARTIAL);
						cap_ff <= (rx_byte == `SHCP_OP_CAP_START);
						temp_ff <= (rx_byte == `SHCP_OP_TEMP_START);
						otp_end_ff <= (rx_byte == `SHCP_OP_OTP_END);
						// result read issued after its opcode.
						if (rx_byte[7:6] == `SHCP_RES_RD_PFX) begin
							res_rd_ff <= 1'b1;
							res_idx_ff <= rx_byte[5:0];
						end
					end
					3'h1: begin
						b1_ff <= rx_byte;
						// SRAM or OTP read address complete.
						if (cls_sram_rd) begin
							mem_rd_ff <= 1'b1;
							mem_otp_ff <= 1'b0;
							mem_addr_ff <= {1'b0, op_ff[3:0], rx_byte};
						end else if (cls_otp_rd) begin
							mem_rd_ff <= 1'b1;
							mem_otp_ff <= 1'b1;
							mem_addr_ff <= {op_ff[4:0], rx_byte};
						end
					end
					3'h2: begin
						b2_ff <= rx_byte;
						// write executes once the data byte arrives.
						if (op_ff[7:4] == `SHCP_SRAM_WR_NIB) begin
							mem_wr_ff <= 1'b1;
							mem_otp_ff <= 1'b0;
							mem_addr_ff <= {1'b0, op_ff[3:0], b1_ff};
							mem_wdata_ff <= rx_byte;
						end else if (op_ff[7:5] == `SHCP_OTP_WR_PFX) begin
							mem_wr_ff <= 1'b1;
							mem_otp_ff <= 1'b1;
							mem_addr_ff <= {op_ff[4:0], b1_ff};
							mem_wdata_ff <= rx_byte;
						end
					end
					3'h3: begin
						// config write after 24 parameter bits.
						// config data only ever flows inward.
						if (op_ff[7:6] == `SHCP_CFG_WR_PFX) begin
							cfg_wr_ff <= 1'b1;
							cfg_idx_ff <= op_ff[5:0];
							cfg_data_ff <= {b1_ff, b2_ff, rx_byte};
						end
					end
					default: begin
						b2_ff <= b2_ff;
					end
				endcase
			end else if (i2c_tx_done && byte_idx_ff != 3'h7) begin
				byte_idx_ff <= byte_idx_ff + 3'h1;
			end
		end
	end

	// Read data are captured the cycle after the request.
	always @(posedge clk_in) begin
		if (srst_in) begin
			rd_wait_ff <= 1'b0;
			res_wait_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			res_data_ff <= 48'h000000000000;
			res_wide_ff <= 1'b0;
		end else begin
			rd_wait_ff <= mem_rd_ff;
			res_wait_ff <= res_rd_ff;
			if (rd_wait_ff) begin
				rd_data_ff <= mem_rdata_in;
			end
			if (res_wait_ff) begin
				res_data_ff <= res_data_in;
				res_wide_ff <= res_wide_in;
			end
		end
	end

	assign por_reset_out = por_ff;
	assign partial_reset_out = partial_ff;
	assign cap_start_out = cap_ff;
	assign temp_start_out = temp_ff;
	assign otp_term_out = otp_end_ff;
	assign mem_wr_out = mem_wr_ff;
	assign mem_rd_out = mem_rd_ff;
	assign mem_otp_out = mem_otp_ff;
	assign mem_addr_out = mem_addr_ff;
	assign mem_wdata_out = mem_wdata_ff;
	assign cfg_wr_out = cfg_wr_ff;
	assign cfg_index_out = cfg_idx_ff;
	assign cfg_data_out = cfg_data_ff;
	assign res_rd_out = res_rd_ff;
	assign res_index_out = res_idx_ff;
endmodule // shcp_top

// ### inc/shcp_regs.vh
`ifndef SHCP_REGS_VH
`define SHCP_REGS_VH

// ==========================================================
// Control opcodes
`define SHCP_OP_POR 8'h88
`define SHCP_OP_PARTIAL 8'h8A
`define SHCP_OP_CAP_START 8'h8C
`define SHCP_OP_TEMP_START 8'h8E
`define SHCP_OP_OTP_END 8'h84
`define SHCP_CTRL_NIBBLE 4'h8

// ==========================================================
// Command class prefixes
`define SHCP_SRAM_WR_NIB 4'h9
`define SHCP_SRAM_RD_NIB 4'h1
`define SHCP_OTP_WR_PFX 3'h5
`define SHCP_OTP_RD_PFX 3'h1
`define SHCP_CFG_WR_PFX 2'h3
`define SHCP_RES_RD_PFX 2'h1

// ==========================================================
// Field widths, I2C address and temperature trigger select
`define SHCP_ADDR_W 13
`define SHCP_IDX_W 6
`define SHCP_I2C_PREFIX 5'h14
`define SHCP_TEMP_TRIG_SW 1'h0

// ==========================================================
// I2C link states
`define SHCP_I2C_IDLE 2'h0
`define SHCP_I2C_ADDR 2'h1
`define SHCP_I2C_WR 2'h2
`define SHCP_I2C_RD 2'h3

`endif

// ### hdl/shcp_sync.v
// ==========================================================
// Two-stage synchroniser for pins from outside the clock domain.
module shcp_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire clk_in,
	input wire srst_in,
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// First stage feeds only the second stage; reset loads the idle pin levels so no false edge follows.
	always @(posedge clk_in) begin
		if (srst_in) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // shcp_sync

// ### tb/shcp_top_properties.sv
`include "shcp_regs.vh"

// ========
// Port-level checker for the host command port.
module shcp_checker (
	input wire clk_in,
	input wire srst_in,
	input wire serial_port_select_pin_in,
	input wire general_port_zero_in,
	input wire general_port_one_oe_out,
	input wire general_ports_spi_owned_out,
	input wire i2c_sda_oe_out,
	input wire por_reset_out,
	input wire partial_reset_out,
	input wire cap_start_out,
	input wire temp_start_out,
	input wire otp_term_out,
	input wire mem_wr_out,
	input wire mem_rd_out,
	input wire mem_otp_out,
	input wire [`SHCP_ADDR_W-1:0] mem_addr_out,
	input wire cfg_wr_out,
	input wire res_rd_out
);
	logic [2:0] up_cnt_ff;
	wire [8:0] pl;

	// All command pulses gathered in one vector.
	assign pl = {por_reset_out, partial_reset_out, cap_start_out, temp_start_out, otp_term_out,
		mem_wr_out, mem_rd_out, cfg_wr_out, res_rd_out};

	// Counts cycles since reset so the synchroniser has settled.
	always @(posedge clk_in) begin
		if (srst_in) begin
			up_cnt_ff <= 3'h0;
		end else if (up_cnt_ff != 3'h7) begin
			up_cnt_ff <= up_cnt_ff + 3'h1;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	property p_port_owner;
		$stable(serial_port_select_pin_in) [*5] ##0 up_cnt_ff == 3'h7
			|-> general_ports_spi_owned_out == !serial_port_select_pin_in;
	endproperty
	a_port_owner: assert property (p_port_owner) else $error("port ownership wrong");
	property p_miso_spi;
		general_port_one_oe_out |-> general_ports_spi_owned_out;
	endproperty
	a_miso_spi: assert property (p_miso_spi) else $error("MISO driven outside SPI");
	property p_i2c_quiet;
		general_ports_spi_owned_out && $past(general_ports_spi_owned_out) |-> !i2c_sda_oe_out;
	endproperty
	a_i2c_quiet: assert property (p_i2c_quiet) else $error("SDA driven in SPI mode");
	property p_sda_i2c;
		$rose(i2c_sda_oe_out) |-> !general_ports_spi_owned_out;
	endproperty
	a_sda_i2c: assert property (p_sda_i2c) else $error("SDA taken without I2C");
	property p_one_cmd;
		$onehot0(pl);
	endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("two commands at once");
	property p_pulse_len;
		|pl |=> pl == 9'h000;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("command pulse too long");
	property p_sram_addr;
		mem_wr_out && !mem_otp_out |-> mem_addr_out[`SHCP_ADDR_W-1] == 1'b0;
	endproperty
	a_sram_addr: assert property (p_sram_addr) else $error("SRAM address too wide");
	property p_spi_framed;
		(|pl) && general_ports_spi_owned_out |-> $past(general_port_zero_in, 2) == 1'b0;
	endproperty
	a_spi_framed: assert property (p_spi_framed) else $error("command outside frame");
	property p_oe_off;
		general_port_zero_in [*6] |-> !general_port_one_oe_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("MISO kept after frame");
endmodule // shcp_checker

bind shcp_top shcp_checker i_chk (.clk_in, .srst_in, .serial_port_select_pin_in, .general_port_zero_in,
	.general_port_one_oe_out, .general_ports_spi_owned_out, .i2c_sda_oe_out, .por_reset_out,
	.partial_reset_out, .cap_start_out, .temp_start_out, .otp_term_out, .mem_wr_out, .mem_rd_out,
	.mem_otp_out, .mem_addr_out, .cfg_wr_out, .res_rd_out);

// ### tb/shcp_host_model.sv
// ========
// Bus master model driving both serial links.
module shcp_host_model (
	input wire clk_in,
	input wire sda_in,
	input wire miso_in,
	output logic sclk_out,
	output logic mosi_out,
	output logic ssn_out,
	output logic scl_out,
	output logic sda_low_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels: SPI clock low, select high, I2C lines released.
	initial begin
		sclk_out = 1'b0;
		mosi_out = 1'b0;
		ssn_out = 1'b1;
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	task tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task spi_frame(input [31:0] d, input int nb, output [31:0] r);
		r = 32'h0;
		ssn_out <= 1'b0;
		tick(4);
		for (int i = nb - 1; i >= 0; i--) begin
			sclk_out <= 1'b1;
			mosi_out <= d[i];
			tick(8);
			sclk_out <= 1'b0;
			r[i] = miso_in;
			tick(8);
		end
		tick(4);
		ssn_out <= 1'b1;
		mosi_out <= ~mosi_out;
		tick(8);
	endtask

	task i2c_bit(input b, output r);
		scl_out <= 1'b0;
		tick(4);
		sda_low_out <= !b;
		tick(4);
		scl_out <= 1'b1;
		tick(4);
		r = sda_in;
		tick(4);
	endtask

	task i2c_start();
		scl_out <= 1'b0;
		tick(4);
		sda_low_out <= 1'b0;
		tick(4);
		scl_out <= 1'b1;
		tick(8);
		sda_low_out <= 1'b1;
		tick(8);
	endtask

	task i2c_stop();
		scl_out <= 1'b0;
		tick(4);
		sda_low_out <= 1'b1;
		tick(4);
		scl_out <= 1'b1;
		tick(8);
		sda_low_out <= 1'b0;
		tick(8);
	endtask

	task i2c_byte(input [7:0] tx, input mack, output [7:0] rx, output ack);
		for (int i = 7; i >= 0; i--) begin
			i2c_bit(tx[i], rx[i]);
		end
		i2c_bit(mack, ack);
	endtask
endmodule // shcp_host_model

// ### tb/shcp_top_tb.sv
`include "shcp_regs.vh"

// ========
// Self-checking bench for the host command port.
module shcp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic serial_port_select_pin_in = 1'b0;
	logic [8:0] seen = 9'h000;
	logic [31:0] rx;
	logic [7:0] rb;
	logic ak;
	logic [1:0] strap = 2'h0;
	logic [47:0] res_val = 48'h000000000000;
	logic res_wide = 1'b0;
	int error_cnt = 0;
	int samples_checked = 0;
	wire spi_sclk_in, spi_mosi_in, general_port_zero_in, i2c_scl_in, sda_low, i2c_sda_in;
	wire general_port_one_out, general_port_one_oe_out, general_ports_spi_owned_out, i2c_sda_out, i2c_sda_oe_out;
	wire por_reset_out, partial_reset_out, cap_start_out, temp_start_out, otp_term_out;
	wire mem_wr_out, mem_rd_out, mem_otp_out, cfg_wr_out, res_rd_out;
	wire [`SHCP_ADDR_W-1:0] mem_addr_out;
	wire [7:0] mem_wdata_out, mem_rdata_in;
	wire [`SHCP_IDX_W-1:0] cfg_index_out, res_index_out;
	wire [23:0] cfg_data_out;

	// Clock, open-drain SDA with pull-up, and a memory whose data follows the address.
	always #5 clk_in = ~clk_in;
	assign i2c_sda_in = !(sda_low || (i2c_sda_oe_out && !i2c_sda_out));
	assign mem_rdata_in = mem_addr_out[7:0] ^ 8'h3C;

	// Collects every command pulse between checks.
	always @(negedge clk_in) begin
		seen = seen | {por_reset_out, partial_reset_out, cap_start_out, temp_start_out, otp_term_out,
			mem_wr_out, mem_rd_out, cfg_wr_out, res_rd_out};
	end

	shcp_top i_dut (.clk_in, .srst_in, .serial_port_select_pin_in, .bus_addr_strap_high_in(strap[1]),
		.bus_addr_strap_low_in(strap[0]), .temp_trigger_source_in(1'b0), .general_port_zero_in, .spi_sclk_in,
		.spi_mosi_in, .general_port_one_out, .general_port_one_oe_out, .general_ports_spi_owned_out,
		.i2c_scl_in, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe_out, .por_reset_out, .partial_reset_out,
		.cap_start_out, .temp_start_out, .otp_term_out, .mem_wr_out, .mem_rd_out, .mem_otp_out,
		.mem_addr_out, .mem_wdata_out, .mem_rdata_in, .cfg_wr_out, .cfg_index_out, .cfg_data_out,
		.res_rd_out, .res_index_out, .res_data_in(res_val), .res_wide_in(res_wide));

	// A released MISO line shows the inverse of general_port_one_out, which is low whenever MISO is released.
	shcp_host_model i_host (.clk_in, .sda_in(i2c_sda_in),
		.miso_in(general_port_one_oe_out ? general_port_one_out : !general_port_one_out),
		.sclk_out(spi_sclk_in), .mosi_out(spi_mosi_in), .ssn_out(general_port_zero_in),
		.scl_out(i2c_scl_in), .sda_low_out(sda_low));

	task check(input [47:0] got, input [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim();
		$display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Sends n bytes after a start, each expecting an acknowledge.
	task i2c_send(input [31:0] b, input int n);
		i_host.i2c_start();
		for (int i = n - 1; i >= 0; i--) begin
			i_host.i2c_byte(b[i*8+:8], 1'b1, rb, ak);
			check(ak, 1'b0);
		end
	endtask

	task t_spi_ctl();
		logic [7:0] ops [5] = '{8'h88, 8'h8A, 8'h8C, 8'h8E, 8'h84};
		check(general_ports_spi_owned_out, 1'b1);
		for (int i = 0; i < 5; i++) begin
			seen = 9'h000;
			i_host.spi_frame({24'h0, ops[i]}, 8, rx);
			check(seen, 9'h100 >> i);
		end
		seen = 9'h000;
		i_host.spi_frame(32'h8, 4, rx);
		check(seen, 9'h000);
		i_host.i2c_start();
		i_host.i2c_byte(8'hA0, 1'b1, rb, ak);
		check(ak, 1'b1);
		i_host.i2c_byte(8'h8C, 1'b1, rb, ak);
		i_host.i2c_stop();
		check(seen, 9'h000);
	endtask

	task t_spi_mem();
		seen = 9'h000;
		i_host.spi_frame(32'h9047FF, 24, rx);
		check({seen, mem_otp_out, mem_addr_out, mem_wdata_out}, {9'h008, 1'b0, 13'h047, 8'hFF});
		seen = 9'h000;
		i_host.spi_frame(32'hA1235A, 24, rx);
		check({seen, mem_otp_out, mem_addr_out, mem_wdata_out}, {9'h008, 1'b1, 13'h123, 8'h5A});
		seen = 9'h000;
		i_host.spi_frame(32'h104700, 24, rx);
		check({seen, rx[7:0]}, {9'h004, 8'h7B});
	endtask

	task t_spi_cfg();
		seen = 9'h000;
		i_host.spi_frame(32'hC5123456, 32, rx);
		check({seen, cfg_index_out, cfg_data_out}, {9'h002, 6'h05, 24'h123456});
	endtask

	// Narrow result read returns the low 24 bits, a wide one starts with the top byte.
	task t_spi_res();
		res_val <= 48'hA1B2C3D4E5F6;
		res_wide <= 1'b0;
		seen = 9'h000;
		i_host.spi_frame(32'h4A000000, 32, rx);
		check({seen, res_index_out, rx[23:0]}, {9'h001, 6'h0A, 24'hD4E5F6});
		res_wide <= 1'b1;
		i_host.spi_frame(32'h4A000000, 32, rx);
		check(rx[23:0], 24'hA1B2C3);
	endtask

	task t_i2c_write();
		serial_port_select_pin_in <= 1'b1;
		i_host.tick(10);
		check(general_ports_spi_owned_out, 1'b0);
		seen = 9'h000;
		i_host.spi_frame(32'h8C, 8, rx);
		check(seen, 9'h000);
		seen = 9'h000;
		i2c_send(32'hA09047FF, 4);
		i_host.i2c_stop();
		check({seen, mem_otp_out, mem_addr_out, mem_wdata_out}, {9'h008, 1'b0, 13'h047, 8'hFF});
	endtask

	task t_i2c_read();
		seen = 9'h000;
		i2c_send(32'hA01047, 3);
		i2c_send(32'hA1, 1);
		i_host.i2c_byte(8'hFF, 1'b1, rb, ak);
		i_host.i2c_stop();
		check({seen, rb}, {9'h004, 8'h7B});
		check(i2c_sda_oe_out, 1'b0);
	endtask

	task t_i2c_addr();
		seen = 9'h000;
		i_host.i2c_start();
		i_host.i2c_byte(8'hA2, 1'b1, rb, ak);
		check(ak, 1'b1);
		i_host.i2c_byte(8'h8C, 1'b1, rb, ak);
		i_host.i2c_stop();
		check(seen, 9'h000);
		i2c_send(32'hA08C, 2);
		i_host.i2c_stop();
		check(seen, 9'h040);
		strap <= 2'h1;
		i_host.tick(4);
		seen = 9'h000;
		i2c_send(32'hA28E, 2);
		i_host.i2c_stop();
		check(seen, 9'h020);
	endtask

	// Main sequence after 20 cycles of reset.
	initial begin
		repeat (20) @(posedge clk_in);
		srst_in <= 1'b0;
		i_host.tick(6);
		t_spi_ctl();
		t_spi_mem();
		t_spi_cfg();
		t_spi_res();
		t_i2c_write();
		t_i2c_read();
		t_i2c_addr();
		end_sim();
	end

	// Cuts a hung run short.
	initial begin
		repeat (50000) @(posedge clk_in);
		error_cnt++;
		end_sim();
	end
endmodule // shcp_top_tb
